// file: core/csp_pkg.sv
// package of the core status and power control register bank
// assumes: single 25 MHz system clock, special register space addressed by 8 bits
package csp_pkg;
  // --------------------------------------------------------------------------
  // special register addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hD0;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'hE0;
  localparam logic [7:0] ADDR_SECOND_ACCUMULATOR = 8'hF0;
  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // --------------------------------------------------------------------------
  // status word fields
  // --------------------------------------------------------------------------
  localparam int PSW_CARRY = 7;
  localparam int PSW_AUX_CARRY = 6;
  localparam int PSW_USER_A = 5;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_OVERFLOW = 2;
  localparam int PSW_USER_B = 1;
  localparam int PSW_PARITY = 0;
  localparam logic [7:0] PSW_SW_MASK = 8'hFE;
  localparam logic [7:0] MUL_LIMIT = 8'hFF;
  // --------------------------------------------------------------------------
  // power control fields
  // --------------------------------------------------------------------------
  localparam int POWER_CONTROL_IDLE = 0;
  localparam int POWER_CONTROL_STOP = 1;
  localparam logic [7:0] POWER_CONTROL_RSVD_MASK = 8'hFC;
  // --------------------------------------------------------------------------
  // arithmetic flag update kinds and power states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CSP_OP_NONE, CSP_OP_ADD, CSP_OP_SUB, CSP_OP_MUL, CSP_OP_DIV, CSP_OP_OTHER
  } csp_op_t;
  typedef enum logic [1:0] {CSP_RUN, CSP_IDLE, CSP_STOP} csp_pwr_t;
endpackage

// file: core/csp_alu_if.sv
// carrier between the register bank and its flag calculator
// assumes: both ends on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface csp_alu_if;
  import csp_pkg::*;
  csp_op_t op;
  logic [7:0] opa;
  logic [7:0] opb;
  logic cin;
  logic carry;
  logic aux_carry;
  logic overflow;
  logic upd_cy;
  logic upd_ov;
  modport calc (input op, opa, opb, cin, output carry, aux_carry, overflow, upd_cy, upd_ov);
  modport bank (output op, opa, opb, cin, input carry, aux_carry, overflow, upd_cy, upd_ov);
endinterface
`default_nettype wire

// file: core/csp_flag_calc.sv
// flag calculator: carry, aux carry and overflow of the finished operation
// assumes: operands stand in the cycle the operation completes
`timescale 1ns/100ps
`default_nettype none
module csp_flag_calc (
  // flag operands and results
  csp_alu_if.calc a
);
  import csp_pkg::*;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [15:0] prod;
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    a.carry = 1'b0;
    a.aux_carry = 1'b0;
    a.overflow = 1'b0;
    a.upd_cy = 1'b0;
    a.upd_ov = 1'b0;
    unique case (a.op)
      CSP_OP_ADD: begin
        sum = {1'b0, a.opa} + {1'b0, a.opb} + {8'h00, a.cin};
        nib = {1'b0, a.opa[3:0]} + {1'b0, a.opb[3:0]} + {4'h0, a.cin};
        a.carry = sum[8]; // R2
        a.aux_carry = nib[4]; // R3
        a.overflow = (a.opa[7] == a.opb[7]) && (sum[7] != a.opa[7]); // R6 R7
        a.upd_cy = 1'b1;
        a.upd_ov = 1'b1;
      end
      CSP_OP_SUB: begin
        sum = {1'b0, a.opa} - {1'b0, a.opb} - {8'h00, a.cin};
        nib = {1'b0, a.opa[3:0]} - {1'b0, a.opb[3:0]} - {4'h0, a.cin};
        a.carry = sum[8]; // R2
        a.aux_carry = nib[4]; // R3
        a.overflow = (a.opa[7] != a.opb[7]) && (sum[7] != a.opa[7]); // R6 R7
        a.upd_cy = 1'b1;
        a.upd_ov = 1'b1;
      end
      CSP_OP_MUL: begin
        prod = {8'h00, a.opa} * {8'h00, a.opb};
        a.overflow = prod > {8'h00, MUL_LIMIT}; // R6
        a.upd_cy = 1'b1;
        a.upd_ov = 1'b1;
      end
      CSP_OP_DIV: begin
        a.overflow = a.opb == RST_BYTE; // R6
        a.upd_cy = 1'b1;
        a.upd_ov = 1'b1;
      end
      CSP_OP_OTHER: begin
        a.upd_cy = 1'b1; // R2 R3
      end
      CSP_OP_NONE: begin
        a.upd_cy = 1'b0;
      end
      default: begin
        a.upd_cy = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: core/csp_regs.sv
// core status and power control register bank (top)
// assumes: special register writes and arithmetic results come from the core pipeline
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1 - data pointer is low and high byte registers, read/write, reset zero
// R2 - carry flag set on add carry or subtract borrow, else cleared
// R3 - aux carry set on nibble carry or borrow, else cleared
// R4 - two user flags in status bits 5 and 1, software only
// R5 - bank select bits 4..3 choose register bank base 0x00,0x08,0x10,0x18
// R6 - overflow set on signed overflow, multiply above 255, or divide by zero
// R7 - overflow cleared by those instructions otherwise
// R8 - status bit 0 is read-only accumulator parity, odd gives one
// R9 - status, accumulator, second accumulator at 0xD0,0xE0,0xF0; second resets zero
// R10 - writing idle select halts processor after instruction, peripherals keep running
// R11 - registers hold their contents throughout idle
// R12 - enabled interrupt ends idle, clears select, resumes and services it
// R13 - reset ending idle restarts execution at 0x0000
// R14 - watchdog reset during idle ends idle
// R15 - writing stop select stops oscillator, processor and digital peripherals
// R16 - in stop only the missing clock detector stays active
// R17 - only reset leaves stop, restarting at 0x0000; interrupts do not wake
// R18 - software disables missing clock detector for stops beyond 100 us
// R19 - select bits read zero, bits 7..2 reserved, register resets zero
// R20 - software never writes one to reserved bits
// R21 - stop wins when one write sets both select bits
module csp_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // special register access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // arithmetic completion
  input wire csp_pkg::csp_op_t alu_op,
  input wire logic [7:0] alu_opa,
  input wire logic [7:0] alu_opb,
  input wire logic alu_acc_wr,
  input wire logic [7:0] alu_acc_val,
  input wire logic instr_done,
  // wake sources
  input wire logic irq_pending,
  // state seen by the core
  output logic [15:0] data_pointer,
  output logic [4:0] bank_base,
  output logic [15:0] reset_vector,
  output logic cpu_halt,
  output logic periph_halt,
  output logic osc_stop,
  output logic resume_pulse
);
  import csp_pkg::*;
  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [7:0] dpl_ff, nxt_dpl;
  logic [7:0] dph_ff, nxt_dph;
  logic [7:0] psw_ff, nxt_psw;
  logic [7:0] acc_ff, nxt_acc;
  logic [7:0] sacc_ff, nxt_sacc;
  logic idle_req_ff, nxt_idle_req;
  logic stop_req_ff, nxt_stop_req;
  csp_pwr_t pwr_ff, nxt_pwr;
  logic resume_ff, nxt_resume;
  logic [7:0] rdata_ff, nxt_rdata;
  logic wr_dpl, wr_dph, wr_psw, wr_acc, wr_sacc, wr_power_control;
  csp_alu_if alu ();
  csp_flag_calc u_calc (
    .a(alu.calc)
  );
  assign alu.op = alu_op;
  assign alu.opa = alu_opa;
  assign alu.opb = alu_opb;
  assign alu.cin = psw_ff[PSW_CARRY];
  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  // registers only change while running; this is what holds them in idle and stop
  logic run;
  assign run = (pwr_ff == CSP_RUN);
  assign wr_dpl = sfr_wr && run && sfr_addr == ADDR_DATA_POINTER_LOW; // R1
  assign wr_dph = sfr_wr && run && sfr_addr == ADDR_DATA_POINTER_HIGH; // R1
  assign wr_psw = sfr_wr && run && sfr_addr == ADDR_PROGRAM_STATUS_WORD; // R9
  assign wr_acc = sfr_wr && run && sfr_addr == ADDR_ACCUMULATOR; // R9
  assign wr_sacc = sfr_wr && run && sfr_addr == ADDR_SECOND_ACCUMULATOR; // R9
  assign wr_power_control = sfr_wr && run && sfr_addr == ADDR_POWER_CONTROL;
  // --------------------------------------------------------------------------
  // data registers
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_dpl = wr_dpl ? sfr_wdata : dpl_ff; // R1 R11
    nxt_dph = wr_dph ? sfr_wdata : dph_ff; // R1 R11
    nxt_sacc = wr_sacc ? sfr_wdata : sacc_ff; // R11
    nxt_acc = acc_ff;
    if (wr_acc) begin
      nxt_acc = sfr_wdata;
    end else if (alu_acc_wr && run) begin
      nxt_acc = alu_acc_val;
    end
  end
  always_comb begin
    nxt_psw = psw_ff;
    if (wr_psw) begin
      nxt_psw = sfr_wdata & PSW_SW_MASK; // R4 R5
    end else if (run && alu.upd_cy) begin
      nxt_psw[PSW_CARRY] = alu.carry; // R2
      nxt_psw[PSW_AUX_CARRY] = alu.aux_carry; // R3
      if (alu.upd_ov) begin
        nxt_psw[PSW_OVERFLOW] = alu.overflow; // R6 R7
      end
    end
    // stored bit 0 unused; parity is recomputed on read
    nxt_psw[PSW_PARITY] = 1'b0;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dpl_ff <= RST_BYTE;
      dph_ff <= RST_BYTE;
      psw_ff <= RST_BYTE;
      acc_ff <= RST_BYTE;
      sacc_ff <= RST_BYTE;
    end else begin
      dpl_ff <= nxt_dpl;
      dph_ff <= nxt_dph;
      psw_ff <= nxt_psw;
      acc_ff <= nxt_acc;
      sacc_ff <= nxt_sacc;
    end
  end
  // --------------------------------------------------------------------------
  // power control
  // --------------------------------------------------------------------------
  // select bits are latched until the instruction that wrote them finishes
  always_comb begin
    nxt_idle_req = idle_req_ff;
    nxt_stop_req = stop_req_ff;
    nxt_pwr = pwr_ff;
    nxt_resume = 1'b0;
    if (wr_power_control) begin
      nxt_stop_req = sfr_wdata[POWER_CONTROL_STOP]; // R15
      nxt_idle_req = sfr_wdata[POWER_CONTROL_IDLE] && !sfr_wdata[POWER_CONTROL_STOP]; // R21
    end
    unique case (pwr_ff)
      CSP_RUN: begin
        if (instr_done && (stop_req_ff || nxt_stop_req)) begin
          nxt_pwr = CSP_STOP; // R15 R21
          nxt_stop_req = 1'b0;
          nxt_idle_req = 1'b0;
        end else if (instr_done && (idle_req_ff || nxt_idle_req)) begin
          nxt_pwr = CSP_IDLE; // R10
        end
      end
      CSP_IDLE: begin
        if (irq_pending) begin
          nxt_pwr = CSP_RUN; // R12
          nxt_idle_req = 1'b0;
          nxt_resume = 1'b1;
        end
      end
      CSP_STOP: begin
        nxt_pwr = CSP_STOP; // R17
      end
    endcase
  end
  // any watchdog or detector reset arrives on resetn and ends both modes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle_req_ff <= 1'b0; // R13 R14 R19
      stop_req_ff <= 1'b0; // R17 R18
      pwr_ff <= CSP_RUN;
      resume_ff <= 1'b0;
    end else begin
      idle_req_ff <= nxt_idle_req;
      stop_req_ff <= nxt_stop_req;
      pwr_ff <= nxt_pwr;
      resume_ff <= nxt_resume;
    end
  end
  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_rdata = rdata_ff;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_DATA_POINTER_LOW: nxt_rdata = dpl_ff;
        ADDR_DATA_POINTER_HIGH: nxt_rdata = dph_ff;
        ADDR_PROGRAM_STATUS_WORD: nxt_rdata = {psw_ff[7:1], ^acc_ff}; // R8
        ADDR_ACCUMULATOR: nxt_rdata = acc_ff;
        ADDR_SECOND_ACCUMULATOR: nxt_rdata = sacc_ff;
        ADDR_POWER_CONTROL: nxt_rdata = RST_BYTE; // R19
        default: nxt_rdata = RST_BYTE;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign sfr_rdata = rdata_ff;
  assign data_pointer = {dph_ff, dpl_ff}; // R1
  assign bank_base = {psw_ff[PSW_BANK_HI], psw_ff[PSW_BANK_LO], 3'b000}; // R5
  assign reset_vector = RESET_VECTOR; // R13 R17
  assign cpu_halt = (pwr_ff != CSP_RUN); // R10 R15
  assign periph_halt = (pwr_ff == CSP_STOP); // R16
  assign osc_stop = (pwr_ff == CSP_STOP); // R15
  assign resume_pulse = resume_ff; // R12
  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // flag checks rebuild the arithmetic from the operands, not from the calculator
  power_control_read_zero_a: assert property ( // R19
    sfr_rd && sfr_addr == ADDR_POWER_CONTROL
    |=> sfr_rdata == RST_BYTE)
    else $error("power control read not zero");
  parity_read_a: assert property ( // R8
    sfr_rd && sfr_addr == ADDR_PROGRAM_STATUS_WORD
    |=> sfr_rdata[PSW_PARITY] == ^$past(acc_ff))
    else $error("parity wrong");
  data_pointer_write_a: assert property ( // R1
    wr_dpl
    |=> data_pointer[7:0] == $past(sfr_wdata))
    else $error("pointer low not written");
  psw_write_a: assert property ( // R4 R5
    wr_psw
    |=> psw_ff == ($past(sfr_wdata) & PSW_SW_MASK))
    else $error("status write not kept");
  add_carry_a: assert property ( // R2
    run && !wr_psw && alu_op == CSP_OP_ADD
    && ({1'b0, alu_opa} + {1'b0, alu_opb} + {8'h00, psw_ff[PSW_CARRY]}) > 9'h0FF
    |=> psw_ff[PSW_CARRY])
    else $error("carry missing");
  add_aux_a: assert property ( // R3
    run && !wr_psw && alu_op == CSP_OP_ADD
    && ({1'b0, alu_opa[3:0]} + {1'b0, alu_opb[3:0]} + {4'h0, psw_ff[PSW_CARRY]}) > 5'h0F
    |=> psw_ff[PSW_AUX_CARRY])
    else $error("aux carry missing");
  add_ov_clear_a: assert property ( // R7
    run && !wr_psw && alu_op == CSP_OP_ADD && alu_opa[7] != alu_opb[7]
    |=> !psw_ff[PSW_OVERFLOW])
    else $error("add overflow not cleared");
  sub_borrow_a: assert property ( // R2
    run && !wr_psw && alu_op == CSP_OP_SUB
    && ({1'b0, alu_opb} + {8'h00, psw_ff[PSW_CARRY]}) > {1'b0, alu_opa}
    |=> psw_ff[PSW_CARRY])
    else $error("borrow missing");
  other_clear_a: assert property ( // R2 R3
    run && !wr_psw && alu_op == CSP_OP_OTHER
    |=> !psw_ff[PSW_CARRY] && !psw_ff[PSW_AUX_CARRY])
    else $error("carry flags not cleared");
  div_zero_a: assert property ( // R6
    run && !wr_psw && alu_op == CSP_OP_DIV && alu_opb == RST_BYTE
    |=> psw_ff[PSW_OVERFLOW])
    else $error("divide by zero overflow missing");
  mul_over_a: assert property ( // R6
    run && !wr_psw && alu_op == CSP_OP_MUL
    && ({8'h00, alu_opa} * {8'h00, alu_opb}) > {8'h00, MUL_LIMIT}
    |=> psw_ff[PSW_OVERFLOW])
    else $error("multiply overflow missing");
  mul_ok_a: assert property ( // R7
    run && !wr_psw && alu_op == CSP_OP_MUL
    && ({8'h00, alu_opa} * {8'h00, alu_opb}) <= {8'h00, MUL_LIMIT}
    |=> !psw_ff[PSW_OVERFLOW] && !psw_ff[PSW_CARRY])
    else $error("overflow not cleared");
  // --------------------------------------------------------------------------
  // power checks
  // --------------------------------------------------------------------------
  stop_sticky_a: assert property ( // R17
    pwr_ff == CSP_STOP
    |=> pwr_ff == CSP_STOP)
    else $error("stop left without reset");
  stop_wins_a: assert property ( // R21
    wr_power_control && sfr_wdata[POWER_CONTROL_STOP] && sfr_wdata[POWER_CONTROL_IDLE] && instr_done
    |=> pwr_ff == CSP_STOP)
    else $error("stop lost precedence");
  idle_entry_a: assert property ( // R10
    wr_power_control && sfr_wdata[POWER_CONTROL_IDLE] && !sfr_wdata[POWER_CONTROL_STOP] && instr_done
    |=> cpu_halt && !osc_stop && !periph_halt)
    else $error("idle not entered");
  idle_stay_a: assert property ( // R10 R12
    pwr_ff == CSP_IDLE && !irq_pending
    |=> pwr_ff == CSP_IDLE)
    else $error("idle left without interrupt");
  idle_wake_a: assert property ( // R12
    pwr_ff == CSP_IDLE && irq_pending
    |=> !cpu_halt && resume_pulse)
    else $error("idle wake failed");
  hold_in_idle_a: assert property ( // R11
    cpu_halt
    |=> $stable(acc_ff) && $stable(dpl_ff) && $stable(dph_ff)
      && $stable(sacc_ff) && $stable(psw_ff))
    else $error("register changed while halted");
  cover_idle_c: cover property (pwr_ff == CSP_IDLE ##[1:20] resume_pulse);
  cover_stop_c: cover property (pwr_ff == CSP_RUN ##1 pwr_ff == CSP_STOP);
  cover_ov_c: cover property (alu_op == CSP_OP_ADD ##1 psw_ff[PSW_OVERFLOW]);
  cover_sub_c: cover property (alu_op == CSP_OP_SUB ##1 psw_ff[PSW_CARRY]);
  cover_both_c: cover property (wr_power_control && sfr_wdata[POWER_CONTROL_STOP] && sfr_wdata[POWER_CONTROL_IDLE]);
endmodule
`default_nettype wire

// file: verif/csp_regs_test.sv
// testbench of the core status and power control register bank
// assumes: csp_pkg and csp_regs compiled first, single 25 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, (act), (exp)); end end
module csp_regs_test;
  import csp_pkg::*;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  csp_op_t alu_op = CSP_OP_NONE;
  logic [7:0] alu_opa = 8'h00;
  logic [7:0] alu_opb = 8'h00;
  logic alu_acc_wr = 1'b0;
  logic [7:0] alu_acc_val = 8'h00;
  logic instr_done = 1'b0;
  logic irq_pending = 1'b0;
  logic [15:0] data_pointer;
  logic [4:0] bank_base;
  logic [15:0] reset_vector;
  logic cpu_halt;
  logic periph_halt;
  logic osc_stop;
  logic resume_pulse;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] q;
  typedef struct packed {
    csp_op_t op;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] ex;
  } csp_row_t;
  // ---------------------------------------------------------------------------
  // ordinary cases: register write or arithmetic (wa/wd as operands), then one read
  // ---------------------------------------------------------------------------
  csp_row_t rows [18] = '{
    '{CSP_OP_NONE, 8'h82, 8'h5A, 8'h82, 8'h5A},
    '{CSP_OP_NONE, 8'h83, 8'hA5, 8'h83, 8'hA5},
    '{CSP_OP_NONE, 8'hF0, 8'h3C, 8'hF0, 8'h3C},
    '{CSP_OP_NONE, 8'hE0, 8'h07, 8'hE0, 8'h07},
    '{CSP_OP_NONE, 8'hD0, 8'hFF, 8'hD0, 8'hFF},
    '{CSP_OP_NONE, 8'hE0, 8'h03, 8'hD0, 8'hFE},
    '{CSP_OP_NONE, 8'hD0, 8'h00, 8'hD0, 8'h00},
    '{CSP_OP_NONE, 8'h81, 8'hFF, 8'h81, 8'h00},
    '{CSP_OP_NONE, 8'h87, 8'h00, 8'h87, 8'h00},
    '{CSP_OP_ADD, 8'hFF, 8'h01, 8'hD0, 8'hC0},
    '{CSP_OP_ADD, 8'h7F, 8'h01, 8'hD0, 8'h44},
    '{CSP_OP_MUL, 8'h10, 8'h10, 8'hD0, 8'h04},
    '{CSP_OP_DIV, 8'h04, 8'h00, 8'hD0, 8'h04},
    '{CSP_OP_DIV, 8'h04, 8'h02, 8'hD0, 8'h00},
    '{CSP_OP_SUB, 8'h00, 8'h01, 8'hD0, 8'hC0},
    '{CSP_OP_MUL, 8'h10, 8'h0F, 8'hD0, 8'h00},
    '{CSP_OP_SUB, 8'h80, 8'h01, 8'hD0, 8'h44},
    '{CSP_OP_OTHER, 8'h00, 8'h00, 8'hD0, 8'h04}
  };
  logic [7:0] rst_addrs [5] = '{8'h82, 8'h83, 8'h87, 8'hD0, 8'hF0};
  // ---------------------------------------------------------------------------
  // design and clock
  // ---------------------------------------------------------------------------
  csp_regs u_dut (.clk_sys(clk_sys), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .alu_op(alu_op),
    .alu_opa(alu_opa), .alu_opb(alu_opb), .alu_acc_wr(alu_acc_wr), .alu_acc_val(alu_acc_val),
    .instr_done(instr_done), .irq_pending(irq_pending), .data_pointer(data_pointer),
    .bank_base(bank_base), .reset_vector(reset_vector), .cpu_halt(cpu_halt),
    .periph_halt(periph_halt), .osc_stop(osc_stop), .resume_pulse(resume_pulse));
  always #20 clk_sys = ~clk_sys;
  // a hung handshake must still end in the verdict
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      close_out();
    end
  end
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic done);
    @(posedge clk_sys); #1;
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1; instr_done = done;
    @(posedge clk_sys); #1;
    sfr_wr = 1'b0; instr_done = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys); #1;
    sfr_addr = a; sfr_rd = 1'b1;
    @(posedge clk_sys); #1;
    sfr_rd = 1'b0; d = sfr_rdata;
  endtask
  task automatic alu(input csp_op_t op, input logic [7:0] a, input logic [7:0] b,
    input logic aw, input logic [7:0] av);
    @(posedge clk_sys); #1;
    alu_op = op; alu_opa = a; alu_opb = b; alu_acc_wr = aw; alu_acc_val = av;
    @(posedge clk_sys); #1;
    alu_op = CSP_OP_NONE; alu_acc_wr = 1'b0;
  endtask
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 resetn = 1'b1;
    `CHK(data_pointer, 16'h0000)
    `CHK({cpu_halt, periph_halt, osc_stop, resume_pulse}, 4'h0)
    foreach (rst_addrs[i]) begin
      rd(rst_addrs[i], q);
      `CHK(q, 8'h00)
    end
    foreach (rows[i]) begin
      if (rows[i].op == CSP_OP_NONE) wr(rows[i].wa, rows[i].wd, 1'b0);
      else alu(rows[i].op, rows[i].wa, rows[i].wd, 1'b0, 8'h00);
      rd(rows[i].ra, q);
      `CHK(q, rows[i].ex)
    end
    `CHK(data_pointer, 16'hA55A)
    for (int i = 0; i < 4; i++) begin
      wr(8'hD0, 8'(i << 3), 1'b0);
      @(posedge clk_sys); #1;
      `CHK(bank_base, 5'(i * 8))
    end
    // accumulator loaded by an arithmetic result, parity follows it
    alu(CSP_OP_NONE, 8'h00, 8'h00, 1'b1, 8'h80);
    rd(8'hD0, q);
    `CHK(q, 8'h19)
    // idle: writes and arithmetic are dropped, interrupt wakes
    wr(8'h87, 8'h01, 1'b1);
    `CHK({cpu_halt, periph_halt, osc_stop}, 3'b100)
    wr(8'h82, 8'h11, 1'b0);
    alu(CSP_OP_ADD, 8'hFF, 8'hFF, 1'b0, 8'h00);
    `CHK(data_pointer, 16'hA55A)
    `CHK(cpu_halt, 1'b1)
    irq_pending = 1'b1;
    @(posedge clk_sys); #1;
    `CHK({cpu_halt, resume_pulse}, 2'b01)
    irq_pending = 1'b0;
    @(posedge clk_sys); #1;
    `CHK(resume_pulse, 1'b0)
    rd(8'h87, q);
    `CHK(q, 8'h00)
    rd(8'hD0, q);
    `CHK(q, 8'h19)
    // stop wins over idle, an interrupt does not wake, only reset does
    wr(8'h87, 8'h03, 1'b1);
    `CHK({cpu_halt, periph_halt, osc_stop}, 3'b111)
    irq_pending = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({cpu_halt, osc_stop, resume_pulse}, 3'b110)
    resetn = 1'b0;
    irq_pending = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 resetn = 1'b1;
    `CHK({cpu_halt, periph_halt, osc_stop}, 3'b000)
    `CHK(reset_vector, 16'h0000)
    `CHK(data_pointer, 16'h0000)
    // idle ended by a watchdog style reset instead of an interrupt
    wr(8'h87, 8'h01, 1'b1);
    `CHK({cpu_halt, osc_stop}, 2'b10)
    resetn = 1'b0;
    @(posedge clk_sys); #1;
    resetn = 1'b1;
    `CHK({cpu_halt, resume_pulse}, 2'b00)
    `CHK(reset_vector, 16'h0000)
    rd(8'h87, q);
    `CHK(q, 8'h00)
    close_out();
  end
endmodule
`default_nettype wire
